// ===== shared/spi_link_pkg.sv
// Shared constants for the serial memory link: byte framing, clock modes, timing.
// Assumes both ends run on one 10 MHz system clock and that the host makes the link clock.
package spi_link_pkg;

    localparam int BYTE_WIDTH = 8;
    localparam int BIT_COUNT_WIDTH = 3;
    localparam logic [BIT_COUNT_WIDTH-1:0] LAST_BIT = 3'h7;
    localparam int FIFO_DEPTH = 4;

    // Idle level of the link clock for the two supported modes
    localparam logic IDLE_LOW_MODE = 1'h0;
    localparam logic IDLE_HIGH_MODE = 1'h1;

    localparam int CLK_PERIOD_NS = 100;
    localparam int LINK_PERIOD_NS = 800;
    // Half a link period in system cycles, rounded up, never below one
    localparam int HALF_RAW = (LINK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_CYCLES = (HALF_RAW < 1) ? 1 : HALF_RAW;
    localparam int DIV_WIDTH = 4;

endpackage

// ===== shared/spi_link_if.sv
// Wires of the serial memory link between the bus master end and the memory end.
// Assumes one instance per pair of ends; a released data-out line reads high.
`timescale 1ns/1ps
interface spi_link_if;
    logic selN;
    logic sclk;
    logic mosi;
    logic misoOut;
    logic misoOeN;
    logic misoLine;
    logic protectN;
    logic holdN;

    // Released line is pulled high, standing in for a floating shared output
    assign misoLine = misoOeN ? 1'h1 : misoOut;

    modport device (
        input selN,
        input sclk,
        input mosi,
        output misoOut,
        output misoOeN
    );

    modport host (
        output selN,
        output sclk,
        output mosi,
        output protectN,
        output holdN,
        input misoLine
    );
endinterface

// ===== rtl/spi_memory_end.sv
// Memory end of the serial link, with a small byte FIFO used on both data paths.
// Assumes link pins are asynchronous to ref_clk and the link clock runs far below it.
`timescale 1ns/1ps

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [CW-1:0] fill;
    logic doPush;
    logic doPop;

    assign inReady = (fill != FULL_COUNT);
    assign outValid = (fill != '0);
    assign outData = store[rdPtr];
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;

    always_ff @(posedge ref_clk) begin
        if (doPush) begin
            store[wrPtr] <= inData;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr <= '0;
            rdPtr <= '0;
            fill <= '0;
        end else begin
            if (doPush) begin
                wrPtr <= (wrPtr == LAST_SLOT) ? '0 : wrPtr + 1'h1;
            end
            if (doPop) begin
                rdPtr <= (rdPtr == LAST_SLOT) ? '0 : rdPtr + 1'h1;
            end
            if (doPush && !doPop) begin
                fill <= fill + 1'h1;
            end else if (doPop && !doPush) begin
                fill <= fill - 1'h1;
            end
        end
    end
endmodule

// How it works
// RULE_01: Incoming bytes assemble most significant bit first.
// RULE_02: First bit taken at first rise after select.
// RULE_03: Outgoing bytes leave most significant bit first.
// RULE_04: Reply starts on fall after last input bit.
// RULE_05: Idle-low and idle-high clock modes both work.
// RULE_06: Capture on rising edge, drive on falling.
// RULE_07: Master parks clock at its mode's idle level.
// RULE_08: Output released whenever not selected.
// RULE_09: Master selects only one memory at once.
// RULE_10: Master holds protect and hold lines defined.
// RULE_11: Deselect ignores clock and restarts bit count.
module spi_memory_end #(
    parameter int DEPTH = spi_link_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic resetn,
    spi_link_if.device link,
    output logic [spi_link_pkg::BYTE_WIDTH-1:0] rxData,
    output logic rxValid,
    input wire logic rxReady,
    output logic rxOverrun,
    input wire logic [spi_link_pkg::BYTE_WIDTH-1:0] txData,
    input wire logic txValid,
    output logic txReady,
    output logic txUnderrun,
    output logic selected
);
    import spi_link_pkg::*;

    logic selMeta, selSync, clkMeta, clkSync, clkPrev, dinMeta, dinSync;
    logic clkRise;
    logic clkFall;
    logic [BIT_COUNT_WIDTH-1:0] bitCount;
    logic [BYTE_WIDTH-1:0] rxShift;
    logic [BYTE_WIDTH-1:0] txShift;
    logic byteDone;
    logic rxPush;
    logic rxSpace;
    logic [BYTE_WIDTH-1:0] rxByte;
    logic [BYTE_WIDTH-1:0] replyData;
    logic replyValid;
    logic replyTake;

    // Pins come from another clock domain, so two flip-flops each
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            selMeta <= 1'h1;
            selSync <= 1'h1;
            clkMeta <= 1'h0;
            clkSync <= 1'h0;
            clkPrev <= 1'h0;
            dinMeta <= 1'h0;
            dinSync <= 1'h0;
        end else begin
            selMeta <= link.selN;
            selSync <= selMeta;
            clkMeta <= link.sclk;
            clkSync <= clkMeta;
            clkPrev <= clkSync;
            dinMeta <= link.mosi;
            dinSync <= dinMeta;
        end
    end

    // Edges are only seen while selected; the idle level of either mode causes no edge
    assign selected = !selSync;
    assign clkRise = selected && clkSync && !clkPrev; // RULE_05 RULE_11
    assign clkFall = selected && !clkSync && clkPrev; // RULE_05 RULE_11

    // Input side: one bit per rising edge, counted from select
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bitCount <= '0;
            rxShift <= '0;
            byteDone <= 1'h0;
        end else if (!selected) begin
            bitCount <= '0; // RULE_11
            byteDone <= 1'h0;
        end else begin
            if (clkRise) begin
                rxShift <= {rxShift[BYTE_WIDTH-2:0], dinSync}; // RULE_01 RULE_02 RULE_06
                bitCount <= bitCount + 1'h1;
                if (bitCount == LAST_BIT) begin
                    byteDone <= 1'h1;
                end
            end else if (clkFall) begin
                byteDone <= 1'h0;
            end
        end
    end

    assign rxByte = {rxShift[BYTE_WIDTH-2:0], dinSync}; // RULE_01
    assign rxPush = clkRise && (bitCount == LAST_BIT);

    // A link master cannot be stalled, so a full FIFO drops the byte and flags it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rxOverrun <= 1'h0;
        end else begin
            rxOverrun <= rxPush && !rxSpace;
        end
    end

    byte_fifo #(
        .WIDTH(BYTE_WIDTH),
        .DEPTH(DEPTH)
    ) rxFifo (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .inData(rxByte),
        .inValid(rxPush),
        .inReady(rxSpace),
        .outData(rxData),
        .outValid(rxValid),
        .outReady(rxReady)
    );

    byte_fifo #(
        .WIDTH(BYTE_WIDTH),
        .DEPTH(DEPTH)
    ) txFifo (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .inData(txData),
        .inValid(txValid),
        .inReady(txReady),
        .outData(replyData),
        .outValid(replyValid),
        .outReady(replyTake)
    );

    // Reply bytes are loaded only at the fall that follows a complete input byte
    assign replyTake = clkFall && byteDone && replyValid; // RULE_04

    // Output side: a new bit appears at each falling edge
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            txShift <= '0;
            link.misoOut <= 1'h0;
            txUnderrun <= 1'h0;
        end else begin
            txUnderrun <= 1'h0;
            if (!selected) begin
                txShift <= '0;
                link.misoOut <= 1'h0;
            end else if (clkFall) begin
                if (byteDone) begin
                    if (replyValid) begin
                        txShift <= {replyData[BYTE_WIDTH-2:0], 1'h0};
                        link.misoOut <= replyData[BYTE_WIDTH-1]; // RULE_03 RULE_04 RULE_06
                    end else begin
                        // Nothing queued: shift zeros rather than stale data
                        txShift <= '0;
                        link.misoOut <= 1'h0;
                        txUnderrun <= 1'h1;
                    end
                end else begin
                    txShift <= {txShift[BYTE_WIDTH-2:0], 1'h0};
                    link.misoOut <= txShift[BYTE_WIDTH-1]; // RULE_03 RULE_06
                end
            end
        end
    end

    // Release the shared line while deselected so another memory may drive it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            link.misoOeN <= 1'h1;
        end else begin
            link.misoOeN <= !selected; // RULE_08 RULE_09
        end
    end
endmodule

// ===== rtl/spi_master_end.sv
// Bus master end of the serial link: makes select, link clock and data out.
// Assumes one memory on the link and a user that queues bytes with a last-byte mark.
`timescale 1ns/1ps
module spi_master_end (
    input wire logic ref_clk,
    input wire logic resetn,
    spi_link_if.host link,
    input wire logic idleHigh,
    input wire logic [spi_link_pkg::BYTE_WIDTH-1:0] txData,
    input wire logic txLast,
    input wire logic txValid,
    output logic txReady,
    output logic [spi_link_pkg::BYTE_WIDTH-1:0] rxData,
    output logic rxValid,
    output logic busy
);
    import spi_link_pkg::*;

    typedef enum logic [2:0] {IDLE, LEAD, LOW, HIGH, TAIL} host_state_type;

    localparam logic [DIV_WIDTH-1:0] HALF_LAST = DIV_WIDTH'(HALF_CYCLES - 1);

    host_state_type state;
    logic [DIV_WIDTH-1:0] divCount;
    logic tick;
    logic modeHigh;
    logic lastByte;
    logic [BIT_COUNT_WIDTH-1:0] bitCount;
    logic [BYTE_WIDTH-1:0] txShift;
    logic [BYTE_WIDTH-1:0] rxShift;
    logic inMeta;
    logic inSync;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            inMeta <= 1'h1;
            inSync <= 1'h1;
        end else begin
            inMeta <= link.misoLine;
            inSync <= inMeta;
        end
    end

    // Half-period enable; restarts with each frame so the first half is full length
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            divCount <= '0;
        end else if (state == IDLE || tick) begin
            divCount <= '0;
        end else begin
            divCount <= divCount + 1'h1;
        end
    end
    assign tick = (state != IDLE) && (divCount == HALF_LAST);

    assign txReady = (state == IDLE) || (state == HIGH && tick && bitCount == LAST_BIT && !lastByte);
    assign busy = (state != IDLE);

    // Protect and hold are unused on this link; parked inactive rather than left floating
    assign link.protectN = 1'h1; // RULE_10
    assign link.holdN = 1'h1; // RULE_10

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= IDLE;
            modeHigh <= IDLE_LOW_MODE;
            link.selN <= 1'h1;
            link.sclk <= 1'h0;
            link.mosi <= 1'h0;
            lastByte <= 1'h0;
            bitCount <= '0;
            txShift <= '0;
            rxShift <= '0;
            rxData <= '0;
            rxValid <= 1'h0;
        end else begin
            rxValid <= 1'h0;
            case (state)
                IDLE: begin
                    modeHigh <= idleHigh;
                    link.sclk <= idleHigh; // RULE_07
                    link.selN <= 1'h1;
                    if (txValid) begin
                        link.selN <= 1'h0; // RULE_09
                        link.mosi <= txData[BYTE_WIDTH-1]; // RULE_01
                        txShift <= txData;
                        lastByte <= txLast;
                        bitCount <= '0;
                        state <= LEAD;
                    end
                end
                LEAD: begin
                    if (tick) begin
                        link.sclk <= 1'h0; // RULE_05
                        state <= LOW;
                    end
                end
                LOW: begin
                    if (tick) begin
                        link.sclk <= 1'h1; // RULE_06
                        state <= HIGH;
                    end
                end
                HIGH: begin
                    // Sample late in the high half to cover both synchroniser delays
                    if (tick) begin
                        rxShift <= {rxShift[BYTE_WIDTH-2:0], inSync}; // RULE_03
                        bitCount <= bitCount + 1'h1;
                        if (bitCount != LAST_BIT) begin
                            link.sclk <= 1'h0;
                            link.mosi <= txShift[BYTE_WIDTH-2]; // RULE_01
                            txShift <= {txShift[BYTE_WIDTH-2:0], 1'h0};
                            state <= LOW;
                        end else begin
                            rxData <= {rxShift[BYTE_WIDTH-2:0], inSync};
                            rxValid <= 1'h1;
                            if (!lastByte && txValid) begin
                                link.sclk <= 1'h0;
                                link.mosi <= txData[BYTE_WIDTH-1];
                                txShift <= txData;
                                lastByte <= txLast;
                                state <= LOW;
                            end else begin
                                // Last byte sent or no byte queued in time: the frame ends here
                                link.sclk <= modeHigh; // RULE_07
                                state <= TAIL;
                            end
                        end
                    end
                end
                TAIL: begin
                    if (tick) begin
                        link.selN <= 1'h1;
                        state <= IDLE;
                    end
                end
                default: begin
                    state <= IDLE;
                end
            endcase
        end
    end
endmodule

// ===== testbench/spi_link_properties.sv
// Link wire checks between the master end and the memory end.
// Assumes one ref_clk domain; inputs come straight from the link interface.
`timescale 1ns/1ps
module spi_link_properties (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic selN,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic misoOut,
    input wire logic misoOeN,
    input wire logic misoLine
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    a_drive_after_select: assert property ($fell(selN) |-> ##[1:4] !misoOeN)
        else $error("data out not driven after select");
    a_release_after_deselect: assert property ($rose(selN) |-> ##[1:4] misoOeN)
        else $error("data out not released after deselect");
    a_released_while_idle: assert property (selN [*5] |-> misoOeN)
        else $error("data out driven while deselected");
    // Tolerates one cycle of slack in the select synchroniser
    a_oe_follows_select: assert property (!misoOeN |-> !$past(selN, 3) || !$past(selN, 4))
        else $error("data out enable without select");
    a_miso_after_fall: assert property ($changed(misoOut) && !misoOeN && !$past(misoOeN)
        |-> !$past(sclk, 3))
        else $error("data out moved without a falling link clock");
    a_mosi_before_rise: assert property ($rose(sclk) && !selN
        |-> $stable(mosi) && mosi == $past(mosi, 3))
        else $error("data in moved near a rising link clock");
    a_lead_clock_still: assert property ($fell(selN) |-> $stable(sclk) [*4])
        else $error("link clock left idle too early");
    a_trail_clock_still: assert property ($rose(selN) |-> $stable(sclk) [*3])
        else $error("link clock moved after deselect");

    cover property ($fell(selN));
    cover property ($rose(selN) ##[1:4] misoOeN);
    cover property ($changed(misoLine) && !selN);
endmodule

// ===== testbench/serial_eeprom_spi_bit_interface_test.sv
// Bench: master end and memory end joined over one link, plus a second
// memory end whose link the bench drives bit by bit.
// Assumes the shared package and the link interface are compiled first.
`timescale 1ns/1ps
module serial_eeprom_spi_bit_interface_test;
    import spi_link_pkg::*;
    logic ref_clk = 1'h0;
    logic resetn = 1'h0;
    logic idleHigh = 1'h0;
    logic [7:0] mTxData = 8'h00;
    logic mTxLast = 1'h0;
    logic mTxValid = 1'h0;
    logic [7:0] dTxData = 8'h00;
    logic dTxValid = 1'h0;
    logic dRxReady = 1'h1;
    logic mTxReady, mRxValid, busy, dRxValid, dTxReady, overrun, underrun, selected, rx2Valid;
    logic [7:0] mRxData, dRxData, rx2Data;
    logic [7:0] pattern = 8'hc3;
    logic prevSclk = 1'h0;
    logic [15:0] wireBits = 16'h0000;
    logic overrunSeen = 1'h0;
    logic underrunSeen = 1'h0;
    logic [7:0] masterRx[$];
    logic [7:0] memRx[$];
    logic [7:0] mem2Rx[$];
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;

    spi_link_if link();
    spi_link_if link2();
    always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

    spi_master_end spi_master_end_inst (.ref_clk(ref_clk), .resetn(resetn), .link(link.host),
        .idleHigh(idleHigh), .txData(mTxData), .txLast(mTxLast), .txValid(mTxValid),
        .txReady(mTxReady), .rxData(mRxData), .rxValid(mRxValid), .busy(busy));
    spi_memory_end spi_memory_end_inst (.ref_clk(ref_clk), .resetn(resetn), .link(link.device),
        .rxData(dRxData), .rxValid(dRxValid), .rxReady(dRxReady), .rxOverrun(overrun),
        .txData(dTxData), .txValid(dTxValid), .txReady(dTxReady), .txUnderrun(underrun),
        .selected(selected));
    // Reply side tied off: this end proves receive framing and data-out release and drive
    spi_memory_end spi_memory_end_inst2 (.ref_clk(ref_clk), .resetn(resetn),
        .link(link2.device), .rxData(rx2Data), .rxValid(rx2Valid), .rxReady(1'h1),
        .rxOverrun(), .txData(8'h00), .txValid(1'h0), .txReady(), .txUnderrun(), .selected());
    spi_link_properties spi_link_properties_inst (.ref_clk(ref_clk), .resetn(resetn),
        .selN(link.selN), .sclk(link.sclk), .mosi(link.mosi), .misoOut(link.misoOut),
        .misoOeN(link.misoOeN), .misoLine(link.misoLine));

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        prevSclk <= link.sclk;
        if (!link.selN && link.sclk && !prevSclk) begin
            wireBits <= {wireBits[14:0], link.mosi};
        end
        if (mRxValid === 1'h1) masterRx.push_back(mRxData);
        if (dRxValid === 1'h1 && dRxReady === 1'h1) memRx.push_back(dRxData);
        if (rx2Valid === 1'h1) mem2Rx.push_back(rx2Data);
        if (overrun === 1'h1) overrunSeen <= 1'h1;
        if (underrun === 1'h1) underrunSeen <= 1'h1;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic check_q(input string what, input logic [7:0] seen[$], input logic [7:0] exp[$]);
        check(what, 16'(seen.size()), 16'(exp.size()));
        foreach (exp[i]) begin
            if (i < seen.size()) check(what, {8'h00, seen[i]}, {8'h00, exp[i]});
        end
    endtask

    // Holds valid across bytes so the master sees a back-to-back frame
    task automatic send_frame(input logic [7:0] bytes[$]);
        int guard;
        @(posedge ref_clk);
        foreach (bytes[i]) begin
            mTxData <= bytes[i];
            mTxLast <= (i == bytes.size() - 1);
            mTxValid <= 1'h1;
            guard = 0;
            do begin
                @(negedge ref_clk);
                guard++;
            end while (mTxReady !== 1'h1 && guard < 200);
            check("master byte taken", 16'(mTxReady), 16'h0001);
            @(posedge ref_clk);
        end
        mTxValid <= 1'h0;
        mTxLast <= 1'h0;
        guard = 0;
        do begin
            @(negedge ref_clk);
            guard++;
        end while (busy !== 1'h0 && guard < 200);
        check("frame ended", 16'(busy), 16'h0000);
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic push_replies(input logic [7:0] bytes[$]);
        int guard;
        @(posedge ref_clk);
        foreach (bytes[i]) begin
            dTxData <= bytes[i];
            dTxValid <= 1'h1;
            guard = 0;
            do begin
                @(negedge ref_clk);
                guard++;
            end while (dTxReady !== 1'h1 && guard < 50);
            check("reply byte taken", 16'(dTxReady), 16'h0001);
            @(posedge ref_clk);
        end
        dTxValid <= 1'h0;
    endtask

    task automatic bit2(input logic b);
        link2.sclk <= 1'h0;
        link2.mosi <= b;
        repeat (HALF_CYCLES) @(posedge ref_clk);
        link2.sclk <= 1'h1;
        repeat (HALF_CYCLES) @(posedge ref_clk);
    endtask

    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        link2.selN = 1'h1;
        link2.sclk = 1'h0;
        link2.mosi = 1'h0;
        link2.protectN = 1'h1;
        link2.holdN = 1'h1;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'h1;
        repeat (4) @(posedge ref_clk);
        check("data out idle", 16'(link.misoLine), 16'h0001);
        check("guard lines", 16'({link.protectN, link.holdN}), 16'h0003);
        push_replies('{8'ha5});
        send_frame('{8'h96, 8'h0f});
        check("mosi bits", wireBits, 16'h960f);
        check("idle low clock", 16'(link.sclk), 16'h0000);
        check("selected", 16'(selected), 16'h0000);
        idleHigh <= 1'h1;
        repeat (8) @(posedge ref_clk);
        check("idle high clock", 16'(link.sclk), 16'h0001);
        push_replies('{8'h5a});
        send_frame('{8'h81, 8'h7e});
        check("mosi bits mode 3", wireBits, 16'h817e);
        dRxReady <= 1'h0;
        push_replies('{8'h01, 8'h02, 8'h03, 8'h04});
        @(negedge ref_clk);
        check("reply buffer full", 16'(dTxReady), 16'h0000);
        send_frame('{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66});
        check("overrun", 16'(overrunSeen), 16'h0001);
        check("underrun", 16'(underrunSeen), 16'h0001);
        dRxReady <= 1'h1;
        repeat (8) @(posedge ref_clk);
        check_q("master rx", masterRx, '{8'h00, 8'ha5, 8'h00, 8'h5a, 8'h00, 8'h01, 8'h02,
            8'h03, 8'h04, 8'h00});
        check_q("memory rx", memRx, '{8'h96, 8'h0f, 8'h81, 8'h7e, 8'h11, 8'h22, 8'h33, 8'h44});
        link2.selN <= 1'h0;
        repeat (8) @(posedge ref_clk);
        bit2(1'h1);
        bit2(1'h0);
        bit2(1'h1);
        link2.selN <= 1'h1;
        repeat (8) @(posedge ref_clk);
        check("second data out idle", 16'(link2.misoLine), 16'h0001);
        bit2(1'h1);
        bit2(1'h0);
        link2.sclk <= 1'h0;
        repeat (8) @(posedge ref_clk);
        link2.selN <= 1'h0;
        repeat (8) @(posedge ref_clk);
        check("second data out driven", 16'(link2.misoLine), 16'h0000);
        for (int i = 7; i >= 0; i--) bit2(pattern[i]);
        link2.sclk <= 1'h0;
        repeat (8) @(posedge ref_clk);
        link2.selN <= 1'h1;
        repeat (8) @(posedge ref_clk);
        check_q("second memory rx", mem2Rx, '{8'hc3});
        wrap_up();
    end
endmodule
